/* File: src/tsc_pkg.sv */
package tsc_pkg;

  localparam int CMD_W = 8;
  localparam int RES_W = 12;
  localparam int CH_W = 3;
  localparam int CMD_CH_HI = 6;
  localparam int CMD_CH_LO = 4;
  localparam int CMD_REF_PD_BIT = 1;
  localparam int CMD_CONV_PD_BIT = 0;
  localparam logic [CMD_W-1:0] CMD_RST = 8'h00;

  // Measurement select field of the command byte
  localparam logic [CH_W-1:0] CH_TEMP0 = 3'h0;
  localparam logic [CH_W-1:0] CH_Y = 3'h1;
  localparam logic [CH_W-1:0] CH_BAT = 3'h2;
  localparam logic [CH_W-1:0] CH_PRESSURE_FIRST = 3'h3;
  localparam logic [CH_W-1:0] CH_PRESSURE_SECOND = 3'h4;
  localparam logic [CH_W-1:0] CH_X = 3'h5;
  localparam logic [CH_W-1:0] CH_AUX = 3'h6;
  localparam logic [CH_W-1:0] CH_TEMP1 = 3'h7;

  // Rising-edge count of the serial clock within one transfer
  localparam logic [4:0] CNT_IDLE = 5'h00;
  localparam logic [4:0] CNT_START = 5'h01;
  localparam logic [4:0] CNT_CMD = 5'h08;
  localparam logic [4:0] CNT_LAST_BIT = 5'h13;
  localparam logic [4:0] CNT_DONE = 5'h14;
  localparam logic [RES_W-1:0] DAC_FIRST_TRIAL = 12'h800;

  typedef enum logic [2:0] {
    PL_OPEN, PL_HIGH, PL_LOW, PL_SENSE, PL_PULLUP
  } tsc_plate_t;

  typedef enum logic {PH_IDLE, PH_MEASURE} tsc_phase_t;

  typedef struct packed {
    tsc_plate_t xp;
    tsc_plate_t yp;
    tsc_plate_t xn;
    tsc_plate_t yn;
  } tsc_plates_t;

endpackage : tsc_pkg

/* File: src/tsc_link_if.sv */
`timescale 1ns/100ps
interface tsc_link_if;
  import tsc_pkg::*;
  logic [CMD_W-1:0] cmd;
  logic cmd_valid;
  logic conv;
  logic [RES_W-1:0] dac;
  logic busy;
  logic dout;
  modport link (output cmd, cmd_valid, conv, dac, busy, dout);
  modport ctrl (input cmd, cmd_valid, conv, dac, busy, dout);
endinterface : tsc_link_if

/* File: src/tsc_link.sv */
`timescale 1ns/100ps
module tsc_link (
  input wire logic i_serial_clock,
  input wire logic i_chip_select_n,
  input wire logic i_cmd_din,
  input wire logic i_cmp_above,
  tsc_link_if.link lk
);
  import tsc_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic [6:0] sr;
    logic [CMD_W-1:0] cmd;
    logic cmd_valid;
    logic conv;
    logic [RES_W-1:0] dac;
    logic bit_val;
  } tsc_link_state_t;

  typedef struct packed {
    logic busy;
    logic dout;
  } tsc_link_out_t;

  tsc_link_state_t link_ff;
  tsc_link_state_t nxt_link;
  tsc_link_out_t out_ff;
  tsc_link_out_t nxt_out;
  logic [3:0] b;

  function automatic logic [3:0] bit_idx(input logic [4:0] cnt);
    logic [4:0] d;
    d = CNT_LAST_BIT - cnt;
    return d[3:0];
  endfunction : bit_idx

  always_comb begin
    nxt_link = link_ff;
    b = bit_idx(link_ff.cnt);
    if (link_ff.cnt == CNT_IDLE || link_ff.cnt == CNT_DONE) begin
      nxt_link.cnt = CNT_IDLE;
      // Idle line is low, so the first high bit opens a command
      if (i_cmd_din) begin
        nxt_link.cnt = CNT_START;
        nxt_link.sr = 7'h01;
        nxt_link.cmd_valid = 1'b0;
      end
    end else if (link_ff.cnt < CNT_CMD) begin
      nxt_link.cnt = link_ff.cnt + 5'h01;
      nxt_link.sr = {link_ff.sr[5:0], i_cmd_din};
      if (link_ff.cnt == CNT_CMD - 5'h01) begin
        nxt_link.cmd = {link_ff.sr, i_cmd_din};
        nxt_link.cmd_valid = 1'b1;
        nxt_link.conv = 1'b1;
        nxt_link.dac = DAC_FIRST_TRIAL;
      end
    end else begin
      // One comparator decision per clock, MSB first
      nxt_link.cnt = link_ff.cnt + 5'h01;
      nxt_link.dac[b] = i_cmp_above;
      if (b != 4'h0) begin
        nxt_link.dac[b - 4'h1] = 1'b1;
      end
      nxt_link.bit_val = i_cmp_above;
      if (link_ff.cnt == CNT_LAST_BIT) begin
        nxt_link.conv = 1'b0;
      end
    end
  end

  always_comb begin
    nxt_out.busy = (link_ff.cnt == CNT_CMD);
    nxt_out.dout = 1'b0;
    if (link_ff.cnt > CNT_CMD && link_ff.cnt <= CNT_DONE) begin
      nxt_out.dout = link_ff.bit_val;
    end
  end

  // Deselect clears the transfer; the clock may stop outside frames
  always_ff @(posedge i_serial_clock or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      link_ff <= '0;
    end else begin
      link_ff <= nxt_link;
    end
  end

  always_ff @(negedge i_serial_clock or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign lk.cmd = link_ff.cmd;
  assign lk.cmd_valid = link_ff.cmd_valid;
  assign lk.conv = link_ff.conv;
  assign lk.dac = link_ff.dac;
  assign lk.busy = out_ff.busy;
  assign lk.dout = out_ff.dout;

  sequence s_start;
    link_ff.cnt == CNT_IDLE && i_cmd_din;
  endsequence

  cmd_frame_a: assert property (
    @(posedge i_serial_clock) disable iff (i_chip_select_n)
    s_start |-> ##8 (lk.cmd_valid && link_ff.cnt == CNT_CMD))
    else $error("command not complete after eight clocks");

  cmd_last_bit_a: assert property (
    @(posedge i_serial_clock) disable iff (i_chip_select_n)
    link_ff.cnt == 5'h07 |=> lk.cmd[0] == $past(i_cmd_din))
    else $error("last command bit not taken on rising edge");

  busy_one_cycle_a: assert property (
    @(negedge i_serial_clock) disable iff (i_chip_select_n)
    $rose(lk.busy) |=> !lk.busy)
    else $error("busy high longer than one clock");

  busy_eighth_a: assert property (
    @(negedge i_serial_clock) disable iff (i_chip_select_n)
    lk.busy |-> $past(link_ff.cnt) == CNT_CMD)
    else $error("busy outside the eighth clock");

  msb_first_a: assert property (
    @(negedge i_serial_clock) disable iff (i_chip_select_n)
    $fell(lk.busy) |-> lk.dout == link_ff.dac[RES_W-1])
    else $error("msb not on data output at busy fall");

  dout_quiet_a: assert property (
    @(negedge i_serial_clock) disable iff (i_chip_select_n)
    (link_ff.cnt >= 5'h02 && link_ff.cnt <= CNT_CMD) |-> !lk.dout)
    else $error("data output not low while no result");

  twelve_bits_a: assert property (
    @(posedge i_serial_clock) disable iff (i_chip_select_n)
    $rose(lk.conv) |-> lk.conv [*6] ##1 lk.conv [*6] ##1 !lk.conv)
    else $error("conversion not twelve clocks long");

endmodule : tsc_link

/* File: src/tsc_ctrl.sv */
`timescale 1ns/100ps
module tsc_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_serial_clock,
  input wire logic i_chip_select_n,
  input wire logic i_cmd_din,
  input wire logic i_cmp_above,
  input wire logic i_pen_touch,
  output logic o_busy,
  output logic o_busy_oe,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_touch_irq_n,
  output logic o_hold,
  output logic [tsc_pkg::RES_W-1:0] o_dac_code,
  output tsc_pkg::tsc_plate_t o_x_plus_plate,
  output tsc_pkg::tsc_plate_t o_y_plus_plate,
  output tsc_pkg::tsc_plate_t o_x_minus_plate,
  output tsc_pkg::tsc_plate_t o_y_minus_plate,
  output logic [tsc_pkg::CH_W-1:0] o_mux_sel,
  output logic o_ref_out_en,
  output logic o_converter_on
);
  import tsc_pkg::*;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic vld_meta;
    logic vld_sync;
    logic vld_prev;
    logic conv_meta;
    logic conv_sync;
    logic conv_prev;
    logic touch_meta;
    logic touch_sync;
    logic [CMD_W-1:0] cmd;
    tsc_phase_t phase;
    tsc_plates_t plates;
    logic [CH_W-1:0] mux;
    logic ref_en;
    logic conv_on;
    logic irq_n;
    logic oe;
  } tsc_ctrl_state_t;

  tsc_ctrl_state_t state_ff;
  tsc_ctrl_state_t nxt_state;
  tsc_link_if lk();
  logic cmd_rise;
  logic conv_fall;
  logic pen_en;
  logic [CH_W-1:0] ch;

  tsc_link u_link (
    .i_serial_clock(i_serial_clock),
    .i_chip_select_n(i_chip_select_n),
    .i_cmd_din(i_cmd_din),
    .i_cmp_above(i_cmp_above),
    .lk(lk.link)
  );

  function automatic tsc_plates_t plate_cfg(
    input logic meas,
    input logic [CH_W-1:0] sel,
    input logic conv_pd
  );
    tsc_plates_t p;
    p = '{PL_OPEN, PL_OPEN, PL_OPEN, PL_OPEN};
    if (!meas) begin
      if (!conv_pd) begin
        p = '{PL_PULLUP, PL_OPEN, PL_OPEN, PL_LOW};
      end
    end else begin
      unique case (sel)
        CH_X: begin
          p = '{PL_HIGH, PL_SENSE, PL_LOW, PL_OPEN};
        end
        CH_Y: begin
          p = '{PL_SENSE, PL_HIGH, PL_OPEN, PL_LOW};
        end
        CH_PRESSURE_FIRST: begin
          p = '{PL_SENSE, PL_HIGH, PL_LOW, PL_OPEN};
        end
        CH_PRESSURE_SECOND: begin
          p = '{PL_OPEN, PL_HIGH, PL_LOW, PL_SENSE};
        end
        CH_TEMP0, CH_BAT, CH_AUX, CH_TEMP1: begin
          p = '{PL_OPEN, PL_OPEN, PL_OPEN, PL_OPEN};
        end
      endcase
    end
    return p;
  endfunction : plate_cfg

  always_comb begin
    nxt_state = state_ff;
    nxt_state.cs_meta = i_chip_select_n;
    nxt_state.cs_sync = state_ff.cs_meta;
    nxt_state.vld_meta = lk.cmd_valid;
    nxt_state.vld_sync = state_ff.vld_meta;
    nxt_state.vld_prev = state_ff.vld_sync;
    nxt_state.conv_meta = lk.conv;
    nxt_state.conv_sync = state_ff.conv_meta;
    nxt_state.conv_prev = state_ff.conv_sync;
    nxt_state.touch_meta = i_pen_touch;
    nxt_state.touch_sync = state_ff.touch_meta;
    cmd_rise = state_ff.vld_sync && !state_ff.vld_prev;
    conv_fall = !state_ff.conv_sync && state_ff.conv_prev;
    // Command word is stable while its valid level is high
    if (cmd_rise) begin
      nxt_state.cmd = lk.cmd;
      nxt_state.phase = PH_MEASURE;
    end else if (conv_fall) begin
      nxt_state.phase = PH_IDLE;
    end
    ch = nxt_state.cmd[CMD_CH_HI:CMD_CH_LO];
    nxt_state.plates = plate_cfg(nxt_state.phase == PH_MEASURE, ch,
      nxt_state.cmd[CMD_CONV_PD_BIT]);
    nxt_state.mux = ch;
    nxt_state.ref_en = nxt_state.cmd[CMD_REF_PD_BIT];
    nxt_state.conv_on = nxt_state.cmd[CMD_CONV_PD_BIT]
      || nxt_state.phase == PH_MEASURE;
    pen_en = !state_ff.cmd[CMD_CONV_PD_BIT];
    // Interrupt only reports the panel while deselected
    nxt_state.irq_n = !(state_ff.cs_sync && pen_en
      && state_ff.touch_sync);
    nxt_state.oe = !state_ff.cs_sync;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= '0;
      state_ff.cs_meta <= 1'b1;
      state_ff.cs_sync <= 1'b1;
      state_ff.cmd <= CMD_RST;
      state_ff.irq_n <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_busy = lk.busy;
  assign o_busy_oe = state_ff.oe;
  assign o_dout = lk.dout;
  assign o_dout_oe = state_ff.oe;
  assign o_touch_irq_n = state_ff.irq_n;
  assign o_hold = lk.conv;
  assign o_dac_code = lk.dac;
  assign o_x_plus_plate = state_ff.plates.xp;
  assign o_y_plus_plate = state_ff.plates.yp;
  assign o_x_minus_plate = state_ff.plates.xn;
  assign o_y_minus_plate = state_ff.plates.yn;
  assign o_mux_sel = state_ff.mux;
  assign o_ref_out_en = state_ff.ref_en;
  assign o_converter_on = state_ff.conv_on;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_select;
    $fell(i_chip_select_n) ##1 !i_chip_select_n [*2];
  endsequence

  sequence s_deselect;
    $rose(i_chip_select_n) ##1 i_chip_select_n [*2];
  endsequence

  sequence s_cmd_seen;
    state_ff.vld_sync && !state_ff.vld_prev;
  endsequence

  sel_drive_a: assert property (
    s_select |=> o_busy_oe && o_dout_oe && o_touch_irq_n)
    else $error("outputs not driven after select");

  desel_float_a: assert property (
    s_deselect |=> !o_busy_oe && !o_dout_oe)
    else $error("outputs still driven after deselect");

  irq_touch_a: assert property (
    (i_chip_select_n && i_pen_touch && pen_en) [*4]
    |-> !o_touch_irq_n)
    else $error("touch not reported while deselected");

  irq_release_a: assert property (
    (i_chip_select_n && !i_pen_touch) [*4] |-> o_touch_irq_n)
    else $error("interrupt low without touch");

  irq_masked_a: assert property (
    !pen_en [*2] |-> o_touch_irq_n)
    else $error("interrupt low while disabled");

  pen_wait_a: assert property (
    o_x_plus_plate == PL_PULLUP |-> o_y_minus_plate == PL_LOW
    && o_y_plus_plate == PL_OPEN && o_x_minus_plate == PL_OPEN
    && state_ff.phase == PH_IDLE)
    else $error("pen waiting plate setup wrong");

  x_axis_a: assert property (
    (state_ff.phase == PH_MEASURE && o_mux_sel == CH_X)
    |-> o_x_plus_plate == PL_HIGH && o_x_minus_plate == PL_LOW
    && o_y_plus_plate == PL_SENSE && o_y_minus_plate == PL_OPEN)
    else $error("x axis plate setup wrong");

  y_axis_a: assert property (
    (state_ff.phase == PH_MEASURE && o_mux_sel == CH_Y)
    |-> o_y_plus_plate == PL_HIGH && o_y_minus_plate == PL_LOW
    && o_x_plus_plate == PL_SENSE && o_x_minus_plate == PL_OPEN)
    else $error("y axis plate setup wrong");

  pressure_plates_a: assert property (
    (state_ff.phase == PH_MEASURE && (o_mux_sel == CH_PRESSURE_FIRST
    || o_mux_sel == CH_PRESSURE_SECOND)) |-> o_y_plus_plate == PL_HIGH
    && o_x_minus_plate == PL_LOW && ((o_mux_sel == CH_PRESSURE_FIRST)
    ? o_x_plus_plate == PL_SENSE : o_y_minus_plate == PL_SENSE))
    else $error("pressure plate setup wrong");

  aux_open_a: assert property (
    (state_ff.phase == PH_MEASURE && (o_mux_sel == CH_TEMP0
    || o_mux_sel == CH_BAT || o_mux_sel == CH_AUX
    || o_mux_sel == CH_TEMP1)) |-> o_x_plus_plate == PL_OPEN
    && o_y_plus_plate == PL_OPEN && o_x_minus_plate == PL_OPEN
    && o_y_minus_plate == PL_OPEN)
    else $error("plates not open for internal input");

  ref_pin_a: assert property (
    s_cmd_seen |=> o_ref_out_en == $past(lk.cmd[CMD_REF_PD_BIT]))
    else $error("reference enable does not follow command");

  power_down_a: assert property (
    (state_ff.phase == PH_MEASURE && state_ff.cmd[1:0] == 2'b00)
    ##1 state_ff.phase == PH_IDLE |-> !o_converter_on && !o_ref_out_en)
    else $error("no full power down between conversions");

  cmd_apply_a: assert property (
    s_cmd_seen |=> state_ff.phase == PH_MEASURE
    && o_mux_sel == $past(lk.cmd[CMD_CH_HI:CMD_CH_LO]))
    else $error("command not applied on next edge");

endmodule : tsc_ctrl

/* File: sim/tsc_host.sv */
`timescale 1ns/100ps
module tsc_host (
  output logic o_serial_clock,
  output logic o_chip_select_n,
  output logic o_cmd_din,
  input wire logic i_busy,
  input wire logic i_dout
);
  import tsc_pkg::*;
  int edge_no;

  // Serial clock stands low between frames
  initial begin
    o_serial_clock = 1'h0;
    o_chip_select_n = 1'h1;
    o_cmd_din = 1'h0;
    edge_no = 0;
  end

  // Samples are taken just before each rising edge
  task automatic xfer(input logic [CMD_W-1:0] cmd,
      output logic [RES_W-1:0] res, output logic [2:0] bsy,
      output logic tail);
    o_chip_select_n = 1'h0;
    #120;
    edge_no = 0;
    for (int i = 1; i <= 22; i++) begin
      o_cmd_din = (i <= CMD_W) ? cmd[CMD_W-i] : 1'h0;
      #32;
      if (i >= 8 && i <= 10) bsy[i-8] = i_busy;
      if (i >= 10 && i <= 21) res[21-i] = i_dout;
      if (i == 22) tail = i_dout;
      o_serial_clock = 1'h1;
      edge_no = i;
      #32;
      o_serial_clock = 1'h0;
    end
    #100;
    o_chip_select_n = 1'h1;
    // Keeps start-to-start spacing above 8 us
    #6800;
  endtask : xfer

  // Clocks with the device deselected and a high data line
  task automatic stray();
    o_cmd_din = 1'h1;
    repeat (8) begin
      #32;
      o_serial_clock = 1'h1;
      #32;
      o_serial_clock = 1'h0;
    end
    o_cmd_din = 1'h0;
  endtask : stray
endmodule : tsc_host

/* File: sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import tsc_pkg::*;
  localparam logic [RES_W-1:0] TGT [8] = '{12'h000, 12'hfff, 12'h800,
    12'h7ff, 12'h001, 12'h555, 12'haaa, 12'h123};
  logic clk, rst, touch, sclk, chip_select_n, din, cmp, busy, boe, dout, doe;
  logic irq_n, hold, refo, con, tail;
  logic [RES_W-1:0] dac, tgt, res;
  logic [CH_W-1:0] mux;
  logic [2:0] bsy;
  tsc_plate_t xp, yp, xn, yn;
  int n_fail, n_checks, cyc;

  // Comparator of the analog core against a fixed input level
  assign cmp = tgt >= dac;

  tsc_host tsc_host_inst (.o_serial_clock(sclk), .o_chip_select_n(chip_select_n),
    .o_cmd_din(din), .i_busy(busy), .i_dout(dout));
  tsc_ctrl tsc_ctrl_inst (.i_clk(clk), .i_rst(rst), .i_serial_clock(sclk),
    .i_chip_select_n(chip_select_n), .i_cmd_din(din), .i_cmp_above(cmp),
    .i_pen_touch(touch), .o_busy(busy), .o_busy_oe(boe), .o_dout(dout),
    .o_dout_oe(doe), .o_touch_irq_n(irq_n), .o_hold(hold),
    .o_dac_code(dac), .o_x_plus_plate(xp), .o_y_plus_plate(yp),
    .o_x_minus_plate(xn), .o_y_minus_plate(yn), .o_mux_sel(mux),
    .o_ref_out_en(refo), .o_converter_on(con));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic check_bit(input logic got, input logic exp,
      input string msg);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check_bit

  task automatic check_code(input logic [RES_W-1:0] got,
      input logic [RES_W-1:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s %h", $time, msg, got);
    end
  endtask : check_code

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Kind per plate: 0 open, 1 driven, 2 sensed, 3 free
  function automatic logic pl_ok(input tsc_plate_t p, input logic [1:0] k);
    return k == 2'h3 || (k == 2'h0 && p === PL_OPEN) ||
      (k == 2'h1 && (p === PL_HIGH || p === PL_LOW)) ||
      (k == 2'h2 && p === PL_SENSE);
  endfunction : pl_ok

  function automatic logic [7:0] plan(input logic [CH_W-1:0] ch);
    case (ch)
      CH_X: return 8'h64;
      CH_Y: return 8'h91;
      CH_PRESSURE_FIRST: return 8'h97;
      CH_PRESSURE_SECOND: return 8'hd6;
      default: return 8'h00;
    endcase
  endfunction : plan

  task automatic test_reset();
    check_bit(boe | doe, 1'h0, "outputs enabled while deselected");
    check_bit(irq_n, 1'h1, "irq low without touch");
    check_bit(xp === PL_PULLUP && yn === PL_LOW, 1'h1, "pen wait");
    check_bit(yp === PL_OPEN, 1'h1, "y plus not open");
    check_bit(con | refo, 1'h0, "power after reset");
  endtask : test_reset

  task automatic test_channel(input logic [CH_W-1:0] ch,
      input logic [RES_W-1:0] t);
    logic [7:0] p;
    logic pd;
    logic rb;
    pd = ch[0];
    rb = ch[1];
    p = plan(ch);
    tgt = t;
    fork
      tsc_host_inst.xfer({1'h1, ch, 2'h0, rb, pd}, res, bsy, tail);
      begin
        #100;
        check_bit(busy | dout, 1'h0, "busy or dout high at select");
        check_bit(boe & doe, 1'h1, "outputs not enabled");
        wait (tsc_host_inst.edge_no == 12);
        check_bit(pl_ok(xp, p[7:6]), 1'h1, "x plus plate");
        check_bit(pl_ok(yp, p[5:4]), 1'h1, "y plus plate");
        check_bit(pl_ok(xn, p[3:2]), 1'h1, "x minus plate");
        check_bit(pl_ok(yn, p[1:0]), 1'h1, "y minus plate");
        check_bit(hold & con, 1'h1, "hold or power off in conversion");
      end
    join
    check_code(res, t, "result");
    check_bit(bsy === 3'h2, 1'h1, "busy window");
    check_bit(tail, 1'h0, "dout after result");
    tick(1);
    check_bit(mux === ch, 1'h1, "channel field");
    check_bit(refo, rb, "reference output");
    check_bit(con, pd, "converter power");
    check_bit(boe | doe, 1'h0, "outputs not released");
    check_bit(pd ? (xp === PL_OPEN && yn === PL_OPEN) : (xp === PL_PULLUP
      && yn === PL_LOW && yp === PL_OPEN), 1'h1, "idle plates");
    touch = 1'h1;
    tick(8);
    check_bit(irq_n, pd, "pen irq with touch");
    touch = 1'h0;
    tick(8);
    check_bit(irq_n, 1'h1, "pen irq without touch");
  endtask : test_channel

  task automatic test_stray();
    tsc_host_inst.stray();
    tick(8);
    check_bit(mux === CH_TEMP0 && con === 1'h0, 1'h1, "deselected cmd");
    check_bit(xp === PL_PULLUP && boe === 1'h0, 1'h1, "deselected state");
  endtask : test_stray

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    rst = 1'h1;
    touch = 1'h0;
    tgt = 12'h000;
    n_fail = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'h0;
    tick(8);
    test_reset();
    for (int c = 7; c >= 0; c--) begin
      test_channel(CH_W'(c), TGT[c]);
    end
    test_stray();
    final_report();
  end
endmodule : testbench
